// ===== rtl/owt_pkg.sv
package owt_pkg;

  // Count source selection codes
  localparam logic [1:0] SRC_F1        = 2'h0;
  localparam logic [1:0] SRC_F2        = 2'h1;
  localparam logic [1:0] SRC_F8        = 2'h2;
  localparam logic [1:0] SRC_COMPANION = 2'h3;

  // Last divider count for each divided source, one less than its division ratio
  localparam logic [2:0] DIV_F2_LAST = 3'h1;
  localparam logic [2:0] DIV_F8_LAST = 3'h7;

  // Digital filter lengths, in clk samples, per filter code
  localparam logic [5:0] FILT_LEN_0 = 6'h00;
  localparam logic [5:0] FILT_LEN_1 = 6'h01;
  localparam logic [5:0] FILT_LEN_2 = 6'h07;
  localparam logic [5:0] FILT_LEN_3 = 6'h1f;

  // Edge polarity codes for single edge triggering
  localparam logic EDGE_FALLING = 1'b0;
  localparam logic EDGE_RISING  = 1'b1;

  // Reset values of reload registers and counters
  localparam logic [7:0] PRESCALE_RST  = 8'hff;
  localparam logic [7:0] PRIMARY_RST   = 8'hff;
  localparam logic [7:0] SECONDARY_RST = 8'hff;

  // Pulse output routing
  localparam logic ROUTE_PIN_A = 1'b0;

  // One-shot phases
  typedef enum logic [1:0] {
    OWT_IDLE,
    OWT_WAIT,
    OWT_PULSE
  } owt_phase_e;

endpackage

// ===== rtl/owt_count_source.sv
module owt_count_source
  import owt_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Selection
  input  wire logic [1:0] sourceSel,
  input  wire logic       companionUnderflow,
  // Count source enable
  output logic            tick
);

  logic [2:0] divCnt;
  logic       nextTick;

  // Free running divider shared by f2 and f8
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      divCnt <= 3'h0;
    end else begin
      divCnt <= divCnt + 3'h1;
    end
  end

  // Source multiplexer; companion underflow is already on clk
  always_comb begin
    nextTick = 1'b0;
    case (sourceSel)
      SRC_F1:  nextTick = 1'b1;
      SRC_F2:  nextTick = ((divCnt & DIV_F2_LAST) == DIV_F2_LAST);
      SRC_F8:  nextTick = ((divCnt & DIV_F8_LAST) == DIV_F8_LAST);
      default: nextTick = companionUnderflow;
    endcase
  end

  // One-cycle enable pulse
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tick <= 1'b0;
    end else begin
      tick <= nextTick;
    end
  end

endmodule

// ===== rtl/owt_pin_trigger.sv
module owt_pin_trigger
  import owt_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // External pin
  input  wire logic       extTriggerPin,
  // Pin configuration
  input  wire logic [1:0] filterSelect,
  input  wire logic       bothEdgeSelect,
  input  wire logic       triggerEdgeBit,
  input  wire logic       interruptEdgeSelect,
  input  wire logic       extInterruptEnable,
  input  wire logic       pinTriggerEnable,
  input  wire logic       irqFlagClear,
  // Results
  output logic            pinTrigger,
  output logic            interruptRequestFlag
);

  logic       pinMeta;
  logic       pinSync;
  logic       pinFilt;
  logic       pinPrev;
  logic [5:0] filtCnt;
  logic [5:0] filtLen;
  logic       riseEdge;
  logic       fallEdge;
  logic       timerEdge;
  logic       intEdge;

  // Two-stage synchroniser on the asynchronous pin
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pinMeta <= 1'b1;
      pinSync <= 1'b1;
    end else begin
      pinMeta <= extTriggerPin;
      pinSync <= pinMeta;
    end
  end

  // Filter length per code
  always_comb begin
    case (filterSelect)
      2'h0:    filtLen = FILT_LEN_0;
      2'h1:    filtLen = FILT_LEN_1;
      2'h2:    filtLen = FILT_LEN_2;
      default: filtLen = FILT_LEN_3;
    endcase
  end

  // Level accepted only after it holds for the filter length
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pinFilt <= 1'b1;
      filtCnt <= 6'h00;
    end else if (pinSync == pinFilt) begin
      filtCnt <= 6'h00;
    end else if (filtCnt >= filtLen) begin
      pinFilt <= pinSync;
      filtCnt <= 6'h00;
    end else begin
      filtCnt <= filtCnt + 6'h01;
    end
  end

  // Edge history of the filtered level
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pinPrev <= 1'b1;
    end else begin
      pinPrev <= pinFilt;
    end
  end

  assign riseEdge = pinFilt & ~pinPrev;
  assign fallEdge = ~pinFilt & pinPrev;

  // Timer and interrupt pick their single edge independently
  assign timerEdge = bothEdgeSelect ? (riseEdge | fallEdge)
                   : ((triggerEdgeBit == EDGE_RISING) ? riseEdge : fallEdge);
  assign intEdge   = bothEdgeSelect ? (riseEdge | fallEdge)
                   : ((interruptEdgeSelect == EDGE_RISING) ? riseEdge : fallEdge);

  // Trigger only when the pin is assigned to the timer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pinTrigger <= 1'b0;
    end else begin
      pinTrigger <= timerEdge & pinTriggerEnable;
    end
  end

  // Request flag follows every selected edge while enabled, timer busy or not; set beats clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      interruptRequestFlag <= 1'b0;
    end else if (intEdge && extInterruptEnable) begin
      interruptRequestFlag <= 1'b1;
    end else if (irqFlagClear) begin
      interruptRequestFlag <= 1'b0;
    end
  end

endmodule

// ===== rtl/owt_wait_oneshot.sv
// Overview of operation
// - A trigger starts a one-shot only while the count status flag is set.
// - Triggers come from a software start write or a pin edge.
// - Active flag rises one to two count source cycles after a trigger.
// - Once active, wait mode counts the wait period first.
// - Triggers while active are ignored; the count does not restart.
// - Pin trigger uses both edges, or one edge chosen by trigger edge bit.
// - Trigger edge bit never affects the pin interrupt polarity.
// - Pin edges during an active one-shot still set the interrupt request flag.
// - Wait the primary duration, then one pulse of secondary duration.
// - Count source is f1, f2, f8 or companion timer underflow.
// - Primary underflow loads the secondary value and counting continues.
// - Secondary underflow reloads primary, ends count, clears active flag.
// - Every stop reloads counters from reload registers.
// - Wait lasts (prescaler+1)(primary+1) count source periods.
// - Pulse lasts (prescaler+1)(secondary+1) count source periods.
// - Stop on completion, stop write, start bit cleared, or forced stop.
// - Timer interrupt raised as the pulse ends after secondary underflow.
// - Pulse active level follows the output level select bit.
// - Pin is plain interrupt input unless pin trigger enable is set.
// - Primary and prescaler reads give live count values.
// - Writes when stopped load reload and counter; when counting, reload only.
// - Route select sends the pulse to one of two pins.
// - Forced stop halts the timer immediately.
// - Status flag rises one to two source cycles after start bit set.
module owt_wait_oneshot
  import owt_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Control bits
  input  wire logic       countStartBit,
  input  wire logic       forcedStopBit,
  input  wire logic       oneshotStartBit,
  input  wire logic       oneshotStopBit,
  // Count source
  input  wire logic [1:0] countSourceSel,
  input  wire logic       companionUnderflow,
  // Counter writes
  input  wire logic [7:0] writeData,
  input  wire logic       prescalerWrite,
  input  wire logic       primaryWrite,
  input  wire logic       secondaryWrite,
  // Pin trigger and interrupt configuration
  input  wire logic       extTriggerPin,
  input  wire logic       pinTriggerEnable,
  input  wire logic [1:0] filterSelect,
  input  wire logic       bothEdgeSelect,
  input  wire logic       triggerEdgeBit,
  input  wire logic       interruptEdgeSelect,
  input  wire logic       extInterruptEnable,
  input  wire logic       irqFlagClear,
  // Output configuration
  input  wire logic       pulseActiveLevel,
  input  wire logic       outputRouteSelect,
  // Status
  output logic            countStatusFlag,
  output logic            oneshotActiveFlag,
  output logic [7:0]      primaryCount,
  output logic [7:0]      prescalerCount,
  output logic            interruptRequestFlag,
  output logic            timerIrq,
  // Pulse pins
  output logic            pulsePinA,
  output logic            pulsePinB
);

  logic       tick;
  logic       pinTrigger;
  logic       trigPend;
  logic       stopPend;
  logic       trigAny;
  logic       preUnder;
  logic       mainUnder;
  logic       stopNow;
  logic       finish;
  logic       pulseOn;
  logic [7:0] preReload;
  logic [7:0] primReload;
  logic [7:0] secReload;
  owt_phase_e phase;

  // Count source selection and divider
  owt_count_source u_source (
    .clk                (clk),
    .rst_b              (rst_b),
    .sourceSel          (countSourceSel),
    .companionUnderflow (companionUnderflow),
    .tick               (tick)
  );

  // Pin synchroniser, filter and edge selection
  owt_pin_trigger u_pin (
    .clk                  (clk),
    .rst_b                (rst_b),
    .extTriggerPin        (extTriggerPin),
    .filterSelect         (filterSelect),
    .bothEdgeSelect       (bothEdgeSelect),
    .triggerEdgeBit       (triggerEdgeBit),
    .interruptEdgeSelect  (interruptEdgeSelect),
    .extInterruptEnable   (extInterruptEnable),
    .pinTriggerEnable     (pinTriggerEnable),
    .irqFlagClear         (irqFlagClear),
    .pinTrigger           (pinTrigger),
    .interruptRequestFlag (interruptRequestFlag)
  );

  // Either trigger cause
  assign trigAny   = oneshotStartBit | pinTrigger;
  // Counter chain underflows, only in active phases
  assign preUnder  = tick && (phase != OWT_IDLE) && (prescalerCount == 8'h00);
  assign mainUnder = preUnder && (primaryCount == 8'h00);
  assign finish    = mainUnder && (phase == OWT_PULSE);
  // Drive starts on the wait underflow edge, so rise and fall see the same register delay
  assign pulseOn   = !forcedStopBit && !stopNow
                     && ((phase == OWT_WAIT && mainUnder) || (phase == OWT_PULSE && !finish));
  // Stop requests that act at a count source edge
  assign stopNow   = tick && (stopPend || !countStartBit) && (phase != OWT_IDLE);

  // Count status flag follows the start bit at a source edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      countStatusFlag <= 1'b0;
    end else if (forcedStopBit) begin
      countStatusFlag <= 1'b0;
    end else if (tick) begin
      countStatusFlag <= countStartBit;
    end
  end

  // Pending trigger, accepted only while idle and enabled
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      trigPend <= 1'b0;
    end else if (forcedStopBit || !countStatusFlag || phase != OWT_IDLE) begin
      trigPend <= 1'b0;
    end else if (trigAny) begin
      trigPend <= 1'b1;
    end else if (tick) begin
      trigPend <= 1'b0;
    end
  end

  // Pending one-shot stop; a stop write while idle is dropped
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stopPend <= 1'b0;
    end else if (oneshotStopBit && phase != OWT_IDLE) begin
      stopPend <= 1'b1;
    end else if (tick || phase == OWT_IDLE) begin
      stopPend <= 1'b0;
    end
  end

  // Phase sequencer and active flag
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phase             <= OWT_IDLE;
      oneshotActiveFlag <= 1'b0;
    end else if (forcedStopBit || stopNow || finish) begin
      phase             <= OWT_IDLE;
      oneshotActiveFlag <= 1'b0;
    end else if (phase == OWT_IDLE && trigPend && tick) begin
      phase             <= OWT_WAIT;
      oneshotActiveFlag <= 1'b1;
    end else if (phase == OWT_WAIT && mainUnder) begin
      phase             <= OWT_PULSE;
    end
  end

  // Reload registers always take writes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      preReload  <= PRESCALE_RST;
      primReload <= PRIMARY_RST;
      secReload  <= SECONDARY_RST;
    end else begin
      if (prescalerWrite) begin
        preReload <= writeData;
      end
      if (primaryWrite) begin
        primReload <= writeData;
      end
      if (secondaryWrite) begin
        secReload <= writeData;
      end
    end
  end

  // Prescaler counter, live value visible on its port
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prescalerCount <= PRESCALE_RST;
    end else if (forcedStopBit || stopNow || finish) begin
      prescalerCount <= preReload;
    end else if (phase == OWT_IDLE) begin
      if (prescalerWrite) begin
        prescalerCount <= writeData;
      end
    end else if (preUnder) begin
      prescalerCount <= preReload;
    end else if (tick) begin
      prescalerCount <= prescalerCount - 8'h01;
    end
  end

  // Main counter: primary during wait, secondary during pulse
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      primaryCount <= PRIMARY_RST;
    end else if (forcedStopBit || stopNow || finish) begin
      primaryCount <= primReload;
    end else if (phase == OWT_IDLE) begin
      if (primaryWrite) begin
        primaryCount <= writeData;
      end
    end else if (mainUnder) begin
      primaryCount <= secReload;
    end else if (preUnder) begin
      primaryCount <= primaryCount - 8'h01;
    end
  end

  // Interrupt pulse at the same edge the pulse ends
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      timerIrq <= 1'b0;
    end else begin
      timerIrq <= finish && !forcedStopBit;
    end
  end

  // Pulse pins; unselected pin rests at the inactive level
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pulsePinA <= 1'b0;
      pulsePinB <= 1'b0;
    end else begin
      pulsePinA <= (outputRouteSelect == ROUTE_PIN_A && pulseOn)
                   ? pulseActiveLevel : ~pulseActiveLevel;
      pulsePinB <= (outputRouteSelect != ROUTE_PIN_A && pulseOn)
                   ? pulseActiveLevel : ~pulseActiveLevel;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence trig_taken_s;
    phase == OWT_IDLE && trigPend && tick && !forcedStopBit;
  endsequence

  sequence pulse_end_s;
    finish && !forcedStopBit;
  endsequence

  no_start_disabled_a: assert property (
    phase == OWT_IDLE && !trigPend && !countStatusFlag |=> phase == OWT_IDLE)
    else $error("one-shot started while counting disabled");

  active_after_trig_a: assert property (
    trig_taken_s |=> oneshotActiveFlag && phase == OWT_WAIT)
    else $error("active flag not set after trigger");

  retrig_ignored_a: assert property (
    oneshotActiveFlag && trigAny |=> !trigPend)
    else $error("retrigger accepted while active");

  secondary_load_a: assert property (
    phase == OWT_WAIT && mainUnder && !forcedStopBit && !stopNow
    |=> phase == OWT_PULSE && primaryCount == $past(secReload))
    else $error("secondary value not loaded at wait underflow");

  end_irq_a: assert property (
    pulse_end_s |=> timerIrq && !oneshotActiveFlag && primaryCount == $past(primReload))
    else $error("pulse end did not raise interrupt or reload");

  forced_halt_a: assert property (
    forcedStopBit |=> phase == OWT_IDLE && !countStatusFlag && !oneshotActiveFlag)
    else $error("forced stop did not halt timer");

  pulse_level_a: assert property (
    phase == OWT_PULSE && !finish && !forcedStopBit && !stopNow && outputRouteSelect == ROUTE_PIN_A
    |=> pulsePinA == $past(pulseActiveLevel) && pulsePinB == !$past(pulseActiveLevel))
    else $error("pulse pin level wrong");

  pulse_start_a: assert property (
    phase == OWT_WAIT && mainUnder && !forcedStopBit && !stopNow && outputRouteSelect == ROUTE_PIN_A
    |=> pulsePinA == $past(pulseActiveLevel))
    else $error("pulse did not start at wait underflow");

  stopped_write_a: assert property (
    primaryWrite && phase == OWT_IDLE && !forcedStopBit |=> primaryCount == $past(writeData))
    else $error("stopped write did not load counter");

  irq_with_pin_a: assert property (
    timerIrq |-> pulsePinA == !pulseActiveLevel || $past(outputRouteSelect) != ROUTE_PIN_A)
    else $error("interrupt without pulse end");

endmodule

// ===== test/owt_trigger_source.sv
module owt_trigger_source #(
  parameter int COMP_PERIOD = 5
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Command from the bench
  input  wire logic pinLevel,
  // Far side outputs
  output logic      extTriggerPin,
  output logic      companionUnderflow
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] compCount;

  // Push-pull source; moves only on command, after the pin path is set up
  assign extTriggerPin = pinLevel;

  // Companion timer underflows at a fixed rate, one cycle each
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      compCount          <= 8'h00;
      companionUnderflow <= 1'b0;
    end else begin
      compCount          <= (compCount == 8'(COMP_PERIOD - 1)) ? 8'h00 : compCount + 8'h01;
      companionUnderflow <= (compCount == 8'(COMP_PERIOD - 1));
    end
  end
endmodule

// ===== test/owt_wait_oneshot_tb_top.sv
module owt_wait_oneshot_tb_top
  import owt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk, rst_b, countStartBit, forcedStopBit, oneshotStartBit, oneshotStopBit;
  logic [1:0] countSourceSel, filterSelect;
  logic [7:0] writeData, primaryCount, prescalerCount;
  logic       companionUnderflow, prescalerWrite, primaryWrite, secondaryWrite, extTriggerPin, pinLevel;
  logic       pinTriggerEnable, bothEdgeSelect, triggerEdgeBit, interruptEdgeSelect, extInterruptEnable;
  logic       irqFlagClear, pulseActiveLevel, outputRouteSelect, countStatusFlag, oneshotActiveFlag;
  logic       interruptRequestFlag, timerIrq, pulsePinA, pulsePinB;
  int         num_errors, comparisons;
  int         divs[4] = '{1, 2, 8, 5};

  owt_wait_oneshot i_owt_wait_oneshot (
    .clk, .rst_b, .countStartBit, .forcedStopBit, .oneshotStartBit, .oneshotStopBit, .countSourceSel,
    .companionUnderflow, .writeData, .prescalerWrite, .primaryWrite, .secondaryWrite, .extTriggerPin,
    .pinTriggerEnable, .filterSelect, .bothEdgeSelect, .triggerEdgeBit, .interruptEdgeSelect,
    .extInterruptEnable, .irqFlagClear, .pulseActiveLevel, .outputRouteSelect, .countStatusFlag,
    .oneshotActiveFlag, .primaryCount, .prescalerCount, .interruptRequestFlag, .timerIrq, .pulsePinA, .pulsePinB
  );

  owt_trigger_source #(.COMP_PERIOD(5)) i_owt_trigger_source (
    .clk, .rst_b, .pinLevel, .extTriggerPin, .companionUnderflow
  );

  // Free clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    if (num_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One-cycle write strobe: 0 prescaler, 1 secondary, 2 primary
  task automatic wr(input int which, input logic [7:0] v);
    writeData      = v;
    prescalerWrite = (which == 0);
    secondaryWrite = (which == 1);
    primaryWrite   = (which == 2);
    cyc(1);
    {prescalerWrite, secondaryWrite, primaryWrite} = 3'h0;
    cyc(1);
  endtask

  // Secondary before primary, then a margin before any trigger
  task automatic setup(input logic [7:0] n, input logic [7:0] m, input logic [7:0] p);
    wr(0, n);
    wr(1, p);
    wr(2, m);
    cyc(8);
    check("primary loaded", {8'h00, primaryCount}, {8'h00, m});
    check("prescaler loaded", {8'h00, prescalerCount}, {8'h00, n});
  endtask

  task automatic clear_flag;
    irqFlagClear = 1'b1;
    cyc(1);
    irqFlagClear = 1'b0;
    cyc(1);
  endtask

  task automatic wait_status;
    int n;
    n = 0;
    while (countStatusFlag !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    check("status rise", 16'(n >= 1 && n <= 2), 16'h0001);
  endtask

  // Software shot; retrigger and a pin edge land mid-wait and must not restart it
  task automatic shot(input int div, input logic [7:0] n, input logic [7:0] m, input logic [7:0] p);
    int   c, tA, tR, tF, tI, tE;
    logic selPin, othBad;
    {tA, tR, tF, tI, tE} = {-32'sd1, -32'sd1, -32'sd1, -32'sd1, -32'sd1};
    c = 0;
    othBad = 1'b0;
    oneshotStartBit = 1'b1;
    while (c < 600 && (tE < 0 || tF < 0 || c < tF + 3)) begin
      @(negedge clk);
      c++;
      oneshotStartBit = (tA > 0 && c == tA + 2);
      if (tA > 0 && c == tA + 3) pinLevel = ~pinLevel;
      selPin = outputRouteSelect ? pulsePinB : pulsePinA;
      if ((outputRouteSelect ? pulsePinA : pulsePinB) !== ~pulseActiveLevel) othBad = 1'b1;
      if (tA < 0 && oneshotActiveFlag === 1'b1) tA = c;
      if (tR < 0 && selPin === pulseActiveLevel) tR = c;
      if (tR >= 0 && tF < 0 && selPin !== pulseActiveLevel) tF = c;
      if (tI < 0 && timerIrq === 1'b1) tI = c;
      if (tA >= 0 && tE < 0 && oneshotActiveFlag !== 1'b1) tE = c;
    end
    check("start delay", 16'(tA >= 2 && tA <= 2 * div + 2), 16'h0001);
    check("wait length", 16'(tR - tA), 16'((n + 1) * (m + 1) * div));
    check("pulse length", 16'(tF - tR), 16'((n + 1) * (p + 1) * div));
    check("irq at pulse end", 16'(tI), 16'(tF));
    check("active cleared", 16'(tE > 0 && tE <= tF), 16'h0001);
    check("unrouted pin idle", {15'h0000, othBad}, 16'h0000);
    check("primary reloaded", {8'h00, primaryCount}, {8'h00, m});
    check("flag during shot", {15'h0000, interruptRequestFlag}, 16'h0001);
    clear_flag();
  endtask

  // Three stop causes, each with a mid-count write that only reaches the reload register
  task automatic stops;
    countSourceSel = SRC_F1;
    for (int k = 0; k < 3; k++) begin
      setup(8'h00, 8'h14, 8'h03);
      oneshotStartBit = 1'b1;
      cyc(1);
      oneshotStartBit = 1'b0;
      cyc(6);
      check("active", {15'h0000, oneshotActiveFlag}, 16'h0001);
      wr(2, 8'h07);
      check("write while counting", {15'h0000, primaryCount !== 8'h07}, 16'h0001);
      oneshotStopBit = (k == 0);
      forcedStopBit  = (k == 1);
      countStartBit  = (k != 2);
      cyc(1);
      oneshotStopBit = 1'b0;
      if (k == 1) check("forced stop", {15'h0000, oneshotActiveFlag}, 16'h0000);
      cyc(3);
      check("stopped", {15'h0000, oneshotActiveFlag}, 16'h0000);
      check("reload on stop", {8'h00, primaryCount}, 16'h0007);
      if (k > 0) check("status cleared", {15'h0000, countStatusFlag}, 16'h0000);
      if (k == 2) begin
        oneshotStartBit = 1'b1;
        cyc(1);
        oneshotStartBit = 1'b0;
        cyc(10);
        check("trigger while disabled", {15'h0000, oneshotActiveFlag}, 16'h0000);
      end
      forcedStopBit = 1'b0;
      countStartBit = 1'b1;
      // A one-shot stop leaves the status flag set, so there is no rise to time
      if (k > 0) wait_status();
    end
  endtask

  // Edge selection for trigger and interrupt, enable gating, filter
  task automatic pins;
    logic both, eb;
    setup(8'h00, 8'h1e, 8'h01);
    filterSelect = 2'h0;
    extInterruptEnable = 1'b1;
    pinTriggerEnable = 1'b1;
    for (int i = 0; i < 4; i++) begin
      {both, eb} = 2'(i);
      bothEdgeSelect = both;
      triggerEdgeBit = eb;
      interruptEdgeSelect = ~eb;
      // Pin idles high, so each pass falls first and then rises
      cyc(60);
      clear_flag();
      pinLevel = 1'b0;
      cyc(12);
      check("fall trigger", {15'h0000, oneshotActiveFlag}, {15'h0000, both | ~eb});
      check("fall flag", {15'h0000, interruptRequestFlag}, {15'h0000, both | eb});
      cyc(60);
      clear_flag();
      pinLevel = 1'b1;
      cyc(12);
      check("rise trigger", {15'h0000, oneshotActiveFlag}, {15'h0000, both | eb});
      check("rise flag", {15'h0000, interruptRequestFlag}, {15'h0000, both | ~eb});
    end
    pinTriggerEnable = 1'b0;
    cyc(60);
    clear_flag();
    pinLevel = 1'b0;
    cyc(12);
    check("plain pin no trigger", {15'h0000, oneshotActiveFlag}, 16'h0000);
    check("plain pin flag", {15'h0000, interruptRequestFlag}, 16'h0001);
    filterSelect = 2'h3;
    pinTriggerEnable = 1'b1;
    cyc(60);
    clear_flag();
    pinLevel = 1'b1;
    cyc(10);
    pinLevel = 1'b0;
    cyc(20);
    check("glitch filtered", {15'h0000, oneshotActiveFlag | interruptRequestFlag}, 16'h0000);
    pinLevel = 1'b1;
    cyc(50);
    check("filtered edge", {14'h0000, oneshotActiveFlag, interruptRequestFlag}, 16'h0003);
  endtask

  // Hang guard, well past the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end

  initial begin
    {rst_b, countStartBit, forcedStopBit, oneshotStartBit, oneshotStopBit, countSourceSel} = 7'h00;
    {writeData, prescalerWrite, primaryWrite, secondaryWrite, pinLevel, pinTriggerEnable} = 13'h0000;
    {filterSelect, bothEdgeSelect, triggerEdgeBit, interruptEdgeSelect, extInterruptEnable} = 6'h00;
    {irqFlagClear, pulseActiveLevel, outputRouteSelect} = 3'h0;
    pinLevel = 1'b1; // Idle high, matching the synchroniser reset, so no edge follows reset
    bothEdgeSelect = 1'b1;
    extInterruptEnable = 1'b1;
    pinTriggerEnable = 1'b1;
    cyc(5);
    rst_b = 1'b1;
    countStartBit = 1'b1;
    wait_status();
    // Every count source, with output level and routing varied alongside
    for (int s = 0; s < 4; s++) begin
      countSourceSel = 2'(s);
      pulseActiveLevel = 1'(s & 1);
      outputRouteSelect = 1'(s >> 1);
      setup(8'(s + 1), 8'h09, 8'h02);
      shot(divs[s], 8'(s + 1), 8'h09, 8'h02);
    end
    stops();
    pins();
    summarize();
  end
endmodule
